// ### shared/adcb_pkg.sv
// Constants for the audio decoder control bank
package adcb_pkg;
  localparam logic [6:0]  DEV_ADDR   = 7'h34;
  localparam int          NREG       = 21;
  localparam logic [7:0]  OFS_FRAME  = 8'h00;
  localparam logic [7:0]  OFS_HDR    = 8'h01;
  localparam logic [7:0]  OFS_SIDE   = 8'h04;
  localparam logic [7:0]  OFS_ERR    = 8'h05;
  // ----------------------------------------------------------------
  // Command register indices into the table below
  // ----------------------------------------------------------------
  localparam int I_RUN = 0;
  localparam int I_FAM = 1;
  localparam int I_DIR = 2;
  localparam int I_SIL = 3;
  localparam int I_ATT = 4;
  localparam int I_SRC = 5;
  localparam int I_OFMT = 6;
  localparam int I_SFMT = 7;
  localparam int I_OSC = 8;
  localparam int I_PLL = 9;
  localparam int I_PLLF = 10;
  localparam int I_TONE = 11;
  localparam int I_LOW = 12;
  localparam int I_HIGH = 13;
  localparam int I_PRE = 14;
  localparam int I_SPAT = 15;
  localparam int I_MLL = 16;
  localparam int I_MRL = 17;
  localparam int I_MLR = 18;
  localparam int I_MRR = 19;
  localparam int I_RATE = 20;
  // Write-only registers are not held in the table
  localparam logic [7:0]  OFS_RESTART = 8'h5a;
  localparam logic [7:0]  OFS_SLEEP   = 8'h5e;
  localparam logic [7:0]  OFS_FPLAY   = 8'h63;
  localparam logic [7:0]  OFS_FSKIP   = 8'h64;
  localparam logic [NREG-1:0][7:0] CREG_OFS = {
    8'h59, 8'h58, 8'h57, 8'h56, 8'h55, 8'h54, 8'h53, 8'h52, 8'h51, 8'h50, 8'h4c,
    8'h4b, 8'h48, 8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40};
  localparam logic [NREG-1:0][15:0] CREG_RST = {
    16'h0000, 16'h0000, 16'h0060, 16'h0060, 16'h0000, 16'h0003, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h7e5e, 16'h3b28, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] FPLAY_RST  = 16'h0006;
  localparam logic [15:0] FSKIP_RST  = 16'h0006;
  localparam logic [15:0] SLEEP_DEEP = 16'h0004;
  // ----------------------------------------------------------------
  // Run and mode codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RUN_STOP  = 16'h0000;
  localparam logic [15:0] RUN_FF    = 16'h0003;
  localparam logic [15:0] RUN_FF2   = 16'h0004;
  localparam logic [15:0] FAM_MPEG  = 16'h0000;
  localparam logic [15:0] FAM_ADPCM = 16'h0001;
  // Start-up strap positions on the general-purpose pins
  localparam int CFG_FAM  = 0;
  localparam int CFG_DIR  = 1;
  localparam int CFG_SRC  = 2;
  localparam int CFG_OFMT = 3;
  localparam int CFG_SFMT = 6;
  // Pins driven after start-up
  localparam logic [15:0] GPIO_OE_MASK = 16'h807f;
endpackage

// ### hdl/adcb_bank.sv
// Audio decoder control bank: start-up straps, status pins and two-wire register bank
`timescale 1ns/100ps
module adcb_bank (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] gpio_in,
  output logic [15:0]      gpio_out,
  output logic [15:0]      gpio_oe,
  input  wire logic        sleep_request_n,
  output logic             core_ready_out,
  output logic             proc_clock_run,
  output logic             pll_clock_run,
  input  wire logic        frame_done,
  input  wire logic        crc_error,
  input  wire logic        stream_error,
  input  wire logic        half_second,
  input  wire logic        bitstream_want,
  input  wire logic [3:0]  encoded_code,
  input  wire logic        encoded_valid,
  input  wire logic [15:0] header_info,
  input  wire logic [7:0]  side_info_bytes,
  output logic             side_info_next,
  output logic             processing_restart,
  output logic             frame_skip,
  output logic [15:0]      run_control,
  output logic [15:0]      codec_family_select,
  output logic [15:0]      adpcm_direction,
  output logic [15:0]      output_silence,
  output logic [15:0]      output_attenuation,
  output logic [15:0]      input_source_select,
  output logic [15:0]      output_port_format,
  output logic [15:0]      second_input_format,
  output logic [15:0]      oversampling_clock_select,
  output logic [15:0]      pll_parameter,
  output logic [15:0]      pll_fraction_parameter,
  output logic [15:0]      tone_or_spatial_select,
  output logic [15:0]      low_band_gain,
  output logic [15:0]      high_band_gain,
  output logic [15:0]      overall_gain_reduction,
  output logic [15:0]      spatial_effect_depth,
  output logic [15:0]      mix_left_to_left,
  output logic [15:0]      mix_right_to_left,
  output logic [15:0]      mix_left_to_right,
  output logic [15:0]      mix_right_to_right,
  output logic [15:0]      adpcm_playback_rate
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100
  } adcb_i2c_e;

  typedef struct packed {
    logic [2:0]                      scl_s;
    logic [2:0]                      sda_s;
    logic [1:0]                      slp_s;
    logic [15:0]                     gp_a;
    logic [15:0]                     gp_b;
    adcb_i2c_e                       st;
    logic [3:0]                      bitcnt;
    logic [7:0]                      shreg;
    logic [7:0]                      tx;
    logic                            rw;
    logic                            addr_ph;
    logic [2:0]                      nbyte;
    logic [7:0]                      ptr;
    logic [7:0]                      wptr;
    logic [15:0]                     wdata;
    logic                            sda_drv;
    logic                            macked;
    logic [adcb_pkg::NREG-1:0][15:0] creg;
    logic [15:0]                     sleep_ctl;
    logic [15:0]                     fplay;
    logic [15:0]                     fskip;
    logic [15:0]                     frames;
    logic [15:0]                     ffcnt;
    logic                            ff_skip;
    logic                            cfg_done;
    logic                            restart;
    logic                            deep;
    logic                            asleep;
    logic                            side_nx;
    logic [15:0]                     gpo;
  } adcb_state_s;

  adcb_state_s r;
  adcb_state_s next_r;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic mpeg_run;
  logic enc_run;
  logic [15:0] rd_word;

  assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
  assign start_c  = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
  assign stop_c   = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
  assign mpeg_run = (r.creg[adcb_pkg::I_FAM] == adcb_pkg::FAM_MPEG) &&
                    (r.creg[adcb_pkg::I_RUN] != adcb_pkg::RUN_STOP);
  assign enc_run  = (r.creg[adcb_pkg::I_FAM] == adcb_pkg::FAM_ADPCM) &&
                    r.creg[adcb_pkg::I_DIR][0] &&
                    (r.creg[adcb_pkg::I_RUN] != adcb_pkg::RUN_STOP);

  // ----------------------------------------------------------------
  // Read multiplexer; write-only and unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    case (r.ptr)
      adcb_pkg::OFS_FRAME: rd_word = r.frames;
      adcb_pkg::OFS_HDR:   rd_word = header_info;
      adcb_pkg::OFS_ERR:   rd_word = {14'h0000, stream_error, crc_error};
      default: begin
        for (int i = 0; i < adcb_pkg::NREG; i++) begin
          if (r.ptr == adcb_pkg::CREG_OFS[i]) begin
            rd_word = r.creg[i];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.scl_s   = {r.scl_s[1:0], scl_in};
    next_r.sda_s   = {r.sda_s[1:0], sda_in};
    next_r.slp_s   = {r.slp_s[0], sleep_request_n};
    next_r.gp_a    = gpio_in;
    next_r.gp_b    = r.gp_a;
    next_r.restart = 1'b0;
    next_r.side_nx = 1'b0;

    // Two-wire slave
    if (start_c) begin
      next_r.st      = ST_RX;
      next_r.bitcnt  = 4'h0;
      next_r.nbyte   = 3'h0;
      next_r.addr_ph = 1'b1;
      next_r.sda_drv = 1'b0;
    end else if (stop_c) begin
      next_r.st      = ST_IDLE;
      next_r.sda_drv = 1'b0;
      if (!r.rw && !r.addr_ph && r.nbyte == 3'h3) begin
        for (int i = 0; i < adcb_pkg::NREG; i++) begin
          if (r.wptr == adcb_pkg::CREG_OFS[i]) begin
            next_r.creg[i] = r.wdata;
          end
        end
        case (r.wptr)
          adcb_pkg::OFS_RESTART: next_r.restart = r.wdata[0];
          adcb_pkg::OFS_SLEEP:   next_r.sleep_ctl = r.wdata;
          adcb_pkg::OFS_FPLAY:   next_r.fplay = r.wdata;
          adcb_pkg::OFS_FSKIP:   next_r.fskip = r.wdata;
          default: begin
          end
        endcase
      end
    end else begin
      case (r.st)
        ST_RX: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], r.sda_s[1]};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            next_r.bitcnt = 4'h0;
            if (r.addr_ph) begin
              if (r.shreg[7:1] == adcb_pkg::DEV_ADDR) begin
                next_r.st      = ST_ACK;
                next_r.sda_drv = 1'b1;
                next_r.rw      = r.shreg[0];
              end else begin
                next_r.st = ST_IDLE;
              end
            end else begin
              next_r.st      = ST_ACK;
              next_r.sda_drv = 1'b1;
              if (r.nbyte != 3'h7) begin
                next_r.nbyte = r.nbyte + 3'h1;
              end
              case (r.nbyte)
                3'h0: begin
                  next_r.wptr = r.shreg;
                  next_r.ptr  = r.shreg;
                end
                3'h1: next_r.wdata[15:8] = r.shreg;
                3'h2: next_r.wdata[7:0]  = r.shreg;
                default: begin
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_r.addr_ph = 1'b0;
            if (r.rw) begin
              // Read always serves the pointer left by the last address byte
              next_r.st      = ST_TX;
              next_r.nbyte   = 3'h1;
              next_r.bitcnt  = 4'h1;
              next_r.tx      = (r.ptr == adcb_pkg::OFS_SIDE) ? side_info_bytes
                                                              : rd_word[15:8];
              next_r.side_nx = (r.ptr == adcb_pkg::OFS_SIDE);
              next_r.sda_drv = (r.ptr == adcb_pkg::OFS_SIDE) ? ~side_info_bytes[7]
                                                              : ~rd_word[15];
            end else begin
              next_r.st      = ST_RX;
              next_r.sda_drv = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'h8) begin
              next_r.st      = ST_TXACK;
              next_r.sda_drv = 1'b0;
            end else begin
              next_r.sda_drv = ~r.tx[3'(4'h7 - r.bitcnt)];
              next_r.bitcnt  = r.bitcnt + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            next_r.macked = ~r.sda_s[1];
          end else if (scl_fall) begin
            if (r.macked) begin
              // Past the word, non-streaming registers just repeat high/low
              next_r.st      = ST_TX;
              next_r.bitcnt  = 4'h1;
              next_r.nbyte   = r.nbyte + 3'h1;
              if (r.ptr == adcb_pkg::OFS_SIDE) begin
                next_r.tx      = side_info_bytes;
                next_r.side_nx = 1'b1;
                next_r.sda_drv = ~side_info_bytes[7];
              end else begin
                next_r.tx      = r.nbyte[0] ? rd_word[7:0] : rd_word[15:8];
                next_r.sda_drv = r.nbyte[0] ? ~rd_word[7] : ~rd_word[15];
              end
            end else begin
              next_r.st = ST_IDLE;
            end
          end
        end
        default: begin
          next_r.sda_drv = 1'b0;
        end
      endcase
    end

    // Start-up straps, caught the cycle after reset is released
    if (!r.cfg_done) begin
      next_r.cfg_done = 1'b1;
      next_r.creg[adcb_pkg::I_FAM][0]   = r.gp_b[adcb_pkg::CFG_FAM];
      next_r.creg[adcb_pkg::I_DIR][0]   = r.gp_b[adcb_pkg::CFG_DIR];
      next_r.creg[adcb_pkg::I_SRC][0]   = r.gp_b[adcb_pkg::CFG_SRC];
      next_r.creg[adcb_pkg::I_OFMT][2:0] = r.gp_b[adcb_pkg::CFG_OFMT +: 3];
      next_r.creg[adcb_pkg::I_SFMT][1:0] = r.gp_b[adcb_pkg::CFG_SFMT +: 2];
    end

    // Frame counter: errors and stop win over counting
    if (crc_error || stream_error ||
        r.creg[adcb_pkg::I_RUN] == adcb_pkg::RUN_STOP) begin
      next_r.frames = 16'h0000;
    end else if (frame_done) begin
      next_r.frames = r.frames + 16'h0001;
    end

    // Fast forward: play fplay frames, skip fskip frames, repeat
    if (mpeg_run && (r.creg[adcb_pkg::I_RUN] == adcb_pkg::RUN_FF ||
                     r.creg[adcb_pkg::I_RUN] == adcb_pkg::RUN_FF2)) begin
      if (frame_done) begin
        if (r.ffcnt + 16'h0001 >= (r.ff_skip ? r.fskip : r.fplay)) begin
          next_r.ffcnt   = 16'h0000;
          next_r.ff_skip = ~r.ff_skip;
        end else begin
          next_r.ffcnt = r.ffcnt + 16'h0001;
        end
      end
    end else begin
      next_r.ffcnt   = 16'h0000;
      next_r.ff_skip = 1'b0;
    end

    // Sleep depth is fixed at the moment the request arrives
    if (!r.slp_s[1] && !r.asleep) begin
      next_r.asleep = 1'b1;
      next_r.deep   = (r.sleep_ctl == adcb_pkg::SLEEP_DEEP);
    end else if (r.slp_s[1]) begin
      next_r.asleep = 1'b0;
      next_r.deep   = 1'b0;
    end

    // Status pins
    next_r.gpo = 16'h0000;
    if (mpeg_run) begin
      next_r.gpo[0]   = header_info[3];
      next_r.gpo[1]   = (header_info[2:1] != 2'b01);
      next_r.gpo[3:2] = header_info[11:10];
      next_r.gpo[4]   = frame_done;
      next_r.gpo[5]   = crc_error | stream_error;
      next_r.gpo[6]   = half_second;
      next_r.gpo[15]  = bitstream_want & ~r.creg[adcb_pkg::I_SRC][0];
    end else if (enc_run) begin
      next_r.gpo[3:0] = encoded_code;
      next_r.gpo[4]   = encoded_valid;
    end

    if (reset) begin
      next_r.st        = ST_IDLE;
      next_r.bitcnt    = 4'h0;
      next_r.shreg     = 8'h00;
      next_r.tx        = 8'h00;
      next_r.rw        = 1'b0;
      next_r.addr_ph   = 1'b0;
      next_r.nbyte     = 3'h0;
      next_r.ptr       = 8'h00;
      next_r.wptr      = 8'h00;
      next_r.wdata     = 16'h0000;
      next_r.sda_drv   = 1'b0;
      next_r.macked    = 1'b0;
      next_r.creg      = adcb_pkg::CREG_RST;
      next_r.sleep_ctl = 16'h0000;
      next_r.fplay     = adcb_pkg::FPLAY_RST;
      next_r.fskip     = adcb_pkg::FSKIP_RST;
      next_r.frames    = 16'h0000;
      next_r.ffcnt     = 16'h0000;
      next_r.ff_skip   = 1'b0;
      next_r.cfg_done  = 1'b0;
      next_r.restart   = 1'b0;
      next_r.deep      = 1'b0;
      next_r.asleep    = 1'b0;
      next_r.side_nx   = 1'b0;
      next_r.gpo       = 16'h0000;
      next_r.scl_s[2]  = 1'b1;
      next_r.sda_s[2]  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_out            = 1'b0;
  assign sda_oe             = r.sda_drv;
  assign gpio_out           = r.gpo;
  assign gpio_oe            = r.cfg_done ? adcb_pkg::GPIO_OE_MASK : 16'h0000;
  assign core_ready_out     = ~r.asleep;
  assign proc_clock_run     = ~r.asleep;
  assign pll_clock_run      = ~r.deep;
  assign side_info_next     = r.side_nx;
  assign processing_restart = r.restart;
  assign frame_skip         = r.ff_skip;
  assign run_control               = r.creg[adcb_pkg::I_RUN];
  assign codec_family_select       = r.creg[adcb_pkg::I_FAM];
  assign adpcm_direction           = r.creg[adcb_pkg::I_DIR];
  assign output_silence            = r.creg[adcb_pkg::I_SIL];
  assign output_attenuation        = r.creg[adcb_pkg::I_ATT];
  assign input_source_select       = r.creg[adcb_pkg::I_SRC];
  assign output_port_format        = r.creg[adcb_pkg::I_OFMT];
  assign second_input_format       = r.creg[adcb_pkg::I_SFMT];
  assign oversampling_clock_select = r.creg[adcb_pkg::I_OSC];
  assign pll_parameter             = r.creg[adcb_pkg::I_PLL];
  assign pll_fraction_parameter    = r.creg[adcb_pkg::I_PLLF];
  assign tone_or_spatial_select    = r.creg[adcb_pkg::I_TONE];
  assign low_band_gain             = r.creg[adcb_pkg::I_LOW];
  assign high_band_gain            = r.creg[adcb_pkg::I_HIGH];
  assign overall_gain_reduction    = r.creg[adcb_pkg::I_PRE];
  assign spatial_effect_depth      = r.creg[adcb_pkg::I_SPAT];
  assign mix_left_to_left          = r.creg[adcb_pkg::I_MLL];
  assign mix_right_to_left         = r.creg[adcb_pkg::I_MRL];
  assign mix_left_to_right         = r.creg[adcb_pkg::I_MLR];
  assign mix_right_to_right        = r.creg[adcb_pkg::I_MRR];
  assign adpcm_playback_rate       = r.creg[adcb_pkg::I_RATE];
endmodule

// ### verification/adcb_bank_sva.sv
// Port-level checks for the audio decoder control bank
`timescale 1ns/100ps
module adcb_bank_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] gpio_oe,
  input wire logic [15:0] gpio_out,
  input wire logic        sleep_request_n,
  input wire logic        core_ready_out,
  input wire logic        pll_clock_run,
  input wire logic        frame_done,
  input wire logic        crc_error,
  input wire logic        stream_error,
  input wire logic        half_second,
  input wire logic        bitstream_want,
  input wire logic [3:0]  encoded_code,
  input wire logic        encoded_valid,
  input wire logic [15:0] header_info,
  input wire logic        processing_restart,
  input wire logic [15:0] run_control,
  input wire logic [15:0] codec_family_select,
  input wire logic [15:0] adpcm_direction,
  input wire logic [15:0] input_source_select
);
  // ----------------------------------------
  // Mode decode and properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire dec = codec_family_select == 16'h0000 && run_control != 16'h0000;
  wire enc = codec_family_select == 16'h0001 && adpcm_direction == 16'h0001
             && run_control != 16'h0000;
  sequence s_doze;
    $fell(sleep_request_n);
  endsequence
  sequence s_ready_drop;
    ##[1:6] !core_ready_out;
  endsequence
  a_oe_in_reset: assert property ($past(reset) |-> gpio_oe == 16'h0000)
    else $error("pins driven during reset");
  a_oe_after_start: assert property (!$past(reset) && !$past(reset, 2)
    |-> gpio_oe == adcb_pkg::GPIO_OE_MASK) else $error("pins not driven after start");
  a_header_pins: assert property ($past(dec) |-> gpio_out[3:0] ==
    {$past(header_info[11:10]), $past(header_info[2:1]) != 2'b01, $past(header_info[3])})
    else $error("header pins mismatch");
  a_frame_pin: assert property ($past(dec) |-> gpio_out[4] == $past(frame_done))
    else $error("frame pin mismatch");
  a_error_pin: assert property ($past(dec) |->
    gpio_out[5] == ($past(crc_error) | $past(stream_error))) else $error("error pin mismatch");
  a_half_pin: assert property ($past(dec) |-> gpio_out[6] == $past(half_second))
    else $error("half second pin mismatch");
  a_demand_pin: assert property ($past(dec) |->
    gpio_out[15] == ($past(bitstream_want) & !$past(input_source_select[0])))
    else $error("demand pin mismatch");
  a_encode_pins: assert property ($past(enc) |->
    gpio_out[4:0] == {$past(encoded_valid), $past(encoded_code)}) else $error("code pins");
  a_sleep_ready: assert property (s_doze |-> s_ready_drop)
    else $error("ready did not drop");
  a_pll_awake: assert property (core_ready_out |-> pll_clock_run)
    else $error("pll stopped while awake");
  a_restart_pulse: assert property (processing_restart |=> !processing_restart)
    else $error("restart longer than one cycle");
endmodule
bind adcb_bank adcb_bank_sva u_sva (.*);

// ### verification/adcb_host.sv
// Host model: two-wire bus master facing the control bank
`timescale 1ns/100ps
module adcb_host (
  input  wire logic clk,
  input  wire logic dev_pull,
  output logic      scl,
  output logic      sda
);
  // ----------------------------------------
  // Bus phases, eight clocks to a bit
  // ----------------------------------------
  logic drv = 1'b1;
  // Pull-up: the line reads high unless someone pulls it down
  assign sda = drv & ~dev_pull;
  initial scl = 1'b1;
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves only with the clock low; start and stop move it with the clock high
  task automatic frame(input logic first);
    scl = 1'b0;
    w(1);
    drv = first;
    w(3);
    scl = 1'b1;
    w(4);
    drv = ~first;
    w(4);
  endtask
  task automatic bit_io(input logic d, output logic r);
    scl = 1'b0;
    w(1);
    drv = d;
    w(3);
    scl = 1'b1;
    w(2);
    r = sda;
    w(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
endmodule

// ### verification/adcb_bank_tb_top.sv
// Self-checking bench for the audio decoder control bank
`timescale 1ns/100ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module adcb_bank_tb_top;
  logic            clk = 1'b0;
  logic            reset = 1'b1;
  logic            scl, sda, sda_out, sda_oe, core_ready_out, proc_clock_run;
  logic            pll_clock_run, side_info_next, processing_restart, frame_skip;
  logic            seen_restart, sleep_request_n = 1'b1, frame_done = 1'b0;
  logic            crc_error = 1'b0, stream_error = 1'b0, half_second = 1'b0;
  logic            bitstream_want = 1'b0, encoded_valid = 1'b0;
  logic [3:0]      encoded_code = 4'h0;
  logic [7:0]      side_info_bytes = 8'h00;
  logic [15:0]     gpio_in = 16'h00a9, header_info = 16'h0000, gpio_out, gpio_oe;
  logic [15:0]     run_control, codec_family_select, adpcm_direction, output_silence,
                   output_attenuation, input_source_select, output_port_format,
                   second_input_format, oversampling_clock_select, pll_parameter,
                   pll_fraction_parameter, tone_or_spatial_select, low_band_gain,
                   high_band_gain, overall_gain_reduction, spatial_effect_depth,
                   mix_left_to_left, mix_right_to_left, mix_left_to_right,
                   mix_right_to_right, adpcm_playback_rate;
  logic [3:0][7:0] b;
  int              n_mismatch = 0, comparisons = 0, cycles = 0;
  adcb_bank DUT (.scl_in(scl), .sda_in(sda), .*);
  adcb_host h (.clk(clk), .dev_pull(sda_oe & ~sda_out), .scl(scl), .sda(sda));
  always #50 clk = ~clk;
  always @(negedge clk) begin
    if (side_info_next) side_info_bytes <= side_info_bytes + 8'h01;
    if (processing_restart) seen_restart <= 1'b1;
  end
  // ----------------------------------------
  // Bus transfers and scenarios
  // ----------------------------------------
  // n data bytes: 2 is a real write, 0 only moves the pointer, 3 is discarded
  task automatic wr(input logic [7:0] r, input logic [15:0] d, input int n);
    logic [7:0] q;
    logic a;
    h.frame(1'b1);
    h.xfer({adcb_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a);
    `CHK(a, 1'b0)
    h.xfer(r, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      h.xfer(i[0] ? d[7:0] : d[15:8], 1'b1, q, a);
      `CHK(a, 1'b0)
    end
    h.frame(1'b0);
    h.w(4);
  endtask
  task automatic rd(input int n);
    logic [7:0] q;
    logic a;
    h.frame(1'b1);
    h.xfer({adcb_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a);
    `CHK(a, 1'b0)
    for (int i = 0; i < n; i++) begin
      h.xfer(8'hff, i == n - 1, q, a);
      b[i] = q;
    end
    h.frame(1'b0);
  endtask
  task automatic t_bus();
    logic [7:0] q;
    logic a;
    `CHK(codec_family_select, 16'h0001)
    `CHK({adpcm_direction, input_source_select}, 32'h0)
    `CHK(output_port_format, 16'h0005)
    `CHK(second_input_format, 16'h0002)
    `CHK(gpio_oe, 16'h807f)
    `CHK({mix_left_to_left, mix_right_to_left}, 32'h00000060)
    `CHK({mix_left_to_right, mix_right_to_right}, 32'h00600000)
    `CHK(adpcm_playback_rate, 16'h0000)
    `CHK({pll_parameter, pll_fraction_parameter}, 32'h3b287e5e)
    for (int v = 4; v >= 0; v--) begin
      wr(8'h40, 16'(v), 2);
      `CHK(run_control, 16'(v))
    end
    wr(8'h44, 16'h0012, 2);
    `CHK(output_attenuation, 16'h0012)
    rd(4);
    `CHK(b, 32'h12001200)
    wr(8'h44, 16'h0033, 3);
    `CHK(output_attenuation, 16'h0012)
    h.frame(1'b1);
    h.xfer({7'h35, 1'b0}, 1'b1, q, a);
    h.frame(1'b0);
    `CHK(a, 1'b1)
    wr(8'h04, 16'h0000, 0);
    q = side_info_bytes;
    rd(3);
    `CHK(b[2:0], {q + 8'h02, q + 8'h01, q})
    $display("bus and register test done");
  endtask
  task automatic t_decode();
    header_info = 16'h080a;
    wr(8'h41, 16'h0000, 2);
    wr(8'h40, 16'h0001, 2);
    repeat (3) begin
      frame_done = 1'b1;
      half_second = 1'b1;
      @(negedge clk);
      frame_done = 1'b0;
      half_second = 1'b0;
      repeat (3) @(negedge clk);
    end
    `CHK(gpio_out[3:0], 4'b1001)
    wr(8'h00, 16'h0000, 0);
    rd(2);
    `CHK(b[1:0], 16'h0300)
    stream_error = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gpio_out[5], 1'b1)
    rd(2);
    `CHK(b[1:0], 16'h0000)
    stream_error = 1'b0;
    crc_error = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gpio_out[5], 1'b1)
    crc_error = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(gpio_out[5], 1'b0)
    bitstream_want = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gpio_out[15], 1'b1)
    wr(8'h45, 16'h0001, 2);
    `CHK(gpio_out[15], 1'b0)
    wr(8'h45, 16'h0000, 2);
    wr(8'h41, 16'h0001, 2);
    wr(8'h42, 16'h0001, 2);
    encoded_code = 4'ha;
    encoded_valid = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gpio_out[4:0], 5'h1a)
    encoded_valid = 1'b0;
    wr(8'h40, 16'h0000, 2);
    $display("status pin test done");
  endtask
  task automatic doze(input logic pll_exp);
    sleep_request_n = 1'b0;
    h.w(6);
    `CHK({core_ready_out, pll_clock_run}, {1'b0, pll_exp})
    `CHK(output_silence, 16'h0001)
    sleep_request_n = 1'b1;
    h.w(6);
    `CHK(core_ready_out, 1'b1)
  endtask
  task automatic t_power();
    wr(8'h43, 16'h0001, 2);
    doze(1'b1);
    wr(8'h5e, 16'h0004, 2);
    doze(1'b0);
    seen_restart = 1'b0;
    wr(8'h45, 16'h0001, 2);
    wr(8'h5a, 16'h0001, 2);
    `CHK({seen_restart, input_source_select}, 17'h10001)
    `CHK(output_attenuation, 16'h0012)
    $display("power and restart test done");
  endtask
  // Second hard reset with other straps: registers return to defaults, straps reload
  task automatic t_restrap();
    gpio_in = 16'h0056;
    reset = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(gpio_oe, 16'h0000)
    reset = 1'b0;
    repeat (6) @(negedge clk);
    `CHK({codec_family_select, adpcm_direction}, 32'h00000001)
    `CHK({input_source_select, output_port_format}, 32'h00010002)
    `CHK(second_input_format, 16'h0001)
    `CHK({output_silence, output_attenuation}, 32'h00000000)
    `CHK(gpio_oe, 16'h807f)
    $display("restrap test done");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run needs about 7500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    `CHK(gpio_oe, 16'h0000)
    reset = 1'b0;
    repeat (6) @(negedge clk);
    t_bus();
    t_decode();
    t_power();
    t_restrap();
    final_report();
  end
endmodule
